// >>> burst_pkg.sv
// shared constants and types for the dual burst pulse generator
package burst_pkg;
  // address width and register byte offsets
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_MODE = 6'h00;
  localparam logic [5:0] OFF_ENABLE = 6'h04;
  localparam logic [5:0] OFF_COUNT_A = 6'h08;
  localparam logic [5:0] OFF_COUNT_B = 6'h0c;
  localparam logic [5:0] OFF_HIGH_A = 6'h10;
  localparam logic [5:0] OFF_LOW_A = 6'h14;
  localparam logic [5:0] OFF_HIGH_B = 6'h18;
  localparam logic [5:0] OFF_LOW_B = 6'h1c;
  localparam logic [5:0] OFF_STATUS = 6'h20;
  // field layout
  localparam int MODE_W = 3;
  localparam int CNT_W = 6;
  localparam int TIME_W = 11;
  localparam int FIRE_A_BIT = 0;
  localparam int FIRE_B_BIT = 1;
  localparam logic [2:0] MODE_DUAL = 3'h3;
  // reset values and the shortest phase time
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [5:0] COUNT_RST = 6'h00;
  localparam logic [10:0] TIME_RST = 11'h000;
  localparam logic [10:0] TIME_MIN = 11'h001;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [TIME_W-1:0] high;
    logic [TIME_W-1:0] low;
  } burst_cfg_t;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'h0,
    GEN_HIGH = 2'h1,
    GEN_LOW = 2'h3
  } gen_state_t;
endpackage

// >>> axi_lite_port.sv
// axi4-lite slave handshake front end with one write and one read slot
`timescale 1ns/10ps
module axi_lite_port
  import burst_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output wr_req_t wr_req,
  output logic wr_en,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  output logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // one register per field, with each channel's flops in a process of its own
  assign wr_req = '{addr: awaddr_r, data: wdata_r, strb: wstrb_r};
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  // writes wait for the previous response to drain, so one write at a time
  assign wr_en = aw_full_r && w_full_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign rd_en = s_axi_arvalid && !rvalid_r;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && !aw_full_r) begin
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && !w_full_r) begin
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_en) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (rd_en) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_err ? RESP_SLVERR : RESP_OKAY;
      rdata_r <= rd_data;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule

// >>> burst_gen.sv
// one burst generator: a counted train of high and low phases
`timescale 1ns/10ps
module burst_gen
  import burst_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic fire,
  input wire logic abort,
  input wire burst_cfg_t cfg,
  // status and drive
  output logic drive,
  output logic busy,
  output logic done
);
  gen_state_t state_r;
  gen_state_t state_nxt;
  burst_cfg_t cfg_r;
  logic [TIME_W-1:0] timer_r;
  logic [CNT_W-1:0] left_r;
  logic drive_r;
  logic done_r;
  logic [TIME_W-1:0] timer_inc;
  logic [TIME_W-1:0] limit;
  logic hit;

  // a zero duration still gives one cycle so the train never stalls
  assign limit = (state_r == GEN_HIGH) ? ((cfg_r.high == TIME_RST) ? TIME_MIN : cfg_r.high)
                                       : ((cfg_r.low == TIME_RST) ? TIME_MIN : cfg_r.low);
  assign timer_inc = timer_r + TIME_MIN;
  assign hit = (timer_inc >= limit);
  assign busy = (state_r != GEN_IDLE);
  assign drive = drive_r;
  assign done = done_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      GEN_IDLE: begin
        if (fire && !abort && cfg.count != COUNT_RST) begin
          state_nxt = GEN_HIGH;
        end
      end
      GEN_HIGH: begin
        if (abort) begin
          state_nxt = GEN_IDLE;
        end else if (hit) begin
          state_nxt = GEN_LOW;
        end
      end
      GEN_LOW: begin
        if (abort) begin
          state_nxt = GEN_IDLE;
        end else if (hit) begin
          state_nxt = (left_r == 6'h01) ? GEN_IDLE : GEN_HIGH;
        end
      end
      default: state_nxt = GEN_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= GEN_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_r <= TIME_RST;
    end else if (state_nxt != state_r) begin
      timer_r <= TIME_RST;
    end else if (state_r != GEN_IDLE) begin
      timer_r <= timer_inc;
    end
  end

  // settings are latched at fire so a rewrite mid-burst cannot tear a pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= '0;
      left_r <= COUNT_RST;
    end else if (state_r == GEN_IDLE && fire) begin
      cfg_r <= cfg;
      left_r <= cfg.count;
    end else if (state_r == GEN_LOW && state_nxt == GEN_HIGH) begin
      left_r <= left_r - 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= (state_nxt == GEN_HIGH);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == GEN_IDLE && fire && !abort && cfg.count == COUNT_RST) ||
                (state_r == GEN_LOW && state_nxt == GEN_IDLE && !abort);
    end
  end
endmodule

// >>> dual_burst_pulse_generator.sv
// two independent burst generators driving the low-side outputs, axi4-lite registers
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module dual_burst_pulse_generator
  import burst_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // low-side drivers
  output logic low_driver_out_a,
  output logic low_driver_out_b
);
  wr_req_t wr_req;
  logic wr_en;
  logic wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_en;
  logic [31:0] rd_data;
  logic rd_err;
  logic [5:0] wr_off;
  logic [5:0] rd_off;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic [MODE_W-1:0] mode_r;
  burst_cfg_t cfg_a_r;
  burst_cfg_t cfg_b_r;
  logic [1:0] done_sticky_r;
  logic mode_dual;
  logic mode_leave;
  logic abort;
  logic fire_a;
  logic fire_b;
  logic busy_a;
  logic busy_b;
  logic done_a;
  logic done_b;
  logic drive_a;
  logic drive_b;

  function automatic logic is_mapped(input logic [5:0] off);
    is_mapped = (off == OFF_MODE) || (off == OFF_ENABLE) || (off == OFF_COUNT_A) ||
                (off == OFF_COUNT_B) || (off == OFF_HIGH_A) || (off == OFF_LOW_A) ||
                (off == OFF_HIGH_B) || (off == OFF_LOW_B) || (off == OFF_STATUS);
  endfunction

  axi_lite_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_req(wr_req),
    .wr_en(wr_en),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // sub-word address bits are ignored, every register is one aligned word
  assign wr_off = {wr_req.addr[5:2], 2'h0};
  assign rd_off = {rd_addr[5:2], 2'h0};
  assign wr_err = !is_mapped(wr_off);
  assign rd_err = !is_mapped(rd_off);

  always_comb begin
    wr_old = 32'h0000_0000;
    unique case (wr_off)
      OFF_MODE: wr_old = {29'h0, mode_r};
      OFF_COUNT_A: wr_old = {26'h0, cfg_a_r.count};
      OFF_COUNT_B: wr_old = {26'h0, cfg_b_r.count};
      OFF_HIGH_A: wr_old = {21'h0, cfg_a_r.high};
      OFF_LOW_A: wr_old = {21'h0, cfg_a_r.low};
      OFF_HIGH_B: wr_old = {21'h0, cfg_b_r.high};
      OFF_LOW_B: wr_old = {21'h0, cfg_b_r.low};
      default: wr_old = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      wr_val[i*8 +: 8] = wr_req.strb[i] ? wr_req.data[i*8 +: 8] : wr_old[i*8 +: 8];
    end
  end

  assign mode_dual = (mode_r == MODE_DUAL);
  // leaving dual mode stops both trains on the same edge the mode changes
  assign mode_leave = wr_en && wr_off == OFF_MODE && wr_val[MODE_W-1:0] != MODE_DUAL;
  assign abort = !mode_dual || mode_leave;
  assign fire_a = wr_en && wr_off == OFF_ENABLE && wr_req.strb[0] &&
                  wr_req.data[FIRE_A_BIT] && mode_dual;
  assign fire_b = wr_en && wr_off == OFF_ENABLE && wr_req.strb[0] &&
                  wr_req.data[FIRE_B_BIT] && mode_dual;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_RST;
    end else if (wr_en && wr_off == OFF_MODE) begin
      mode_r <= wr_val[MODE_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_a_r <= {COUNT_RST, TIME_RST, TIME_RST};
      cfg_b_r <= {COUNT_RST, TIME_RST, TIME_RST};
    end else if (wr_en) begin
      if (wr_off == OFF_COUNT_A) cfg_a_r.count <= wr_val[CNT_W-1:0];
      if (wr_off == OFF_COUNT_B) cfg_b_r.count <= wr_val[CNT_W-1:0];
      if (wr_off == OFF_HIGH_A) cfg_a_r.high <= wr_val[TIME_W-1:0];
      if (wr_off == OFF_LOW_A) cfg_a_r.low <= wr_val[TIME_W-1:0];
      if (wr_off == OFF_HIGH_B) cfg_b_r.high <= wr_val[TIME_W-1:0];
      if (wr_off == OFF_LOW_B) cfg_b_r.low <= wr_val[TIME_W-1:0];
    end
  end

  // done flags: a new completion wins over a simultaneous write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_sticky_r <= 2'h0;
    end else if (wr_en && wr_off == OFF_STATUS && wr_req.strb[0]) begin
      done_sticky_r <= (done_sticky_r & ~wr_req.data[1:0]) | {done_b, done_a};
    end else begin
      done_sticky_r <= done_sticky_r | {done_b, done_a};
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_off)
      OFF_MODE: rd_data = {29'h0, mode_r};
      OFF_ENABLE: rd_data = {30'h0, busy_b, busy_a};
      OFF_COUNT_A: rd_data = {26'h0, cfg_a_r.count};
      OFF_COUNT_B: rd_data = {26'h0, cfg_b_r.count};
      OFF_HIGH_A: rd_data = {21'h0, cfg_a_r.high};
      OFF_LOW_A: rd_data = {21'h0, cfg_a_r.low};
      OFF_HIGH_B: rd_data = {21'h0, cfg_b_r.high};
      OFF_LOW_B: rd_data = {21'h0, cfg_b_r.low};
      OFF_STATUS: rd_data = {30'h0, done_sticky_r};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  burst_gen u_gen_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .fire(fire_a),
    .abort(abort),
    .cfg(cfg_a_r),
    .drive(drive_a),
    .busy(busy_a),
    .done(done_a)
  );

  burst_gen u_gen_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .fire(fire_b),
    .abort(abort),
    .cfg(cfg_b_r),
    .drive(drive_b),
    .busy(busy_b),
    .done(done_b)
  );

  assign low_driver_out_a = drive_a;
  assign low_driver_out_b = drive_b;

  // checking helpers: latched settings, pulse tally and phase lengths per channel
  logic [1:0] outs;
  logic [1:0] busys;
  logic [1:0] fires;
  logic [1:0] dones;
  burst_cfg_t lat_cfg [2];
  logic [CNT_W:0] pulses [2];
  logic [TIME_W:0] hi_run [2];
  logic [TIME_W:0] lo_run [2];
  logic [TIME_W-1:0] hi_exp [2];
  logic [TIME_W-1:0] lo_exp [2];
  assign outs = {low_driver_out_b, low_driver_out_a};
  assign busys = {busy_b, busy_a};
  assign fires = {fire_b, fire_a};
  assign dones = {done_b, done_a};

  for (genvar g = 0; g < 2; g++) begin : g_chk
    logic out_q;
    logic low_q;
    assign hi_exp[g] = (lat_cfg[g].high == TIME_RST) ? TIME_MIN : lat_cfg[g].high;
    assign lo_exp[g] = (lat_cfg[g].low == TIME_RST) ? TIME_MIN : lat_cfg[g].low;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        lat_cfg[g] <= '0;
        pulses[g] <= '0;
        hi_run[g] <= '0;
        lo_run[g] <= '0;
        out_q <= 1'b0;
        low_q <= 1'b0;
      end else begin
        out_q <= outs[g];
        low_q <= busys[g] && !outs[g];
        if (fires[g] && !busys[g]) begin
          lat_cfg[g] <= (g == 0) ? cfg_a_r : cfg_b_r;
          pulses[g] <= '0;
          lo_run[g] <= '0;
        end else begin
          if (outs[g] && !out_q) pulses[g] <= pulses[g] + 7'h01;
          if (busys[g] && !outs[g]) lo_run[g] <= low_q ? lo_run[g] + 12'h001 : 12'h001;
        end
        if (outs[g]) hi_run[g] <= out_q ? hi_run[g] + 12'h001 : 12'h001;
      end
    end
  end

  AST_A_ONLY_GEN: assert property (@(posedge aclk) disable iff (!aresetn)
    low_driver_out_a |-> busy_a && mode_dual) else $error("output a driven outside burst a");
  AST_B_ONLY_GEN: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_b && !fire_a && !busy_a |=> !busy_a && !low_driver_out_a)
    else $error("firing b disturbed channel a");
  AST_A_INDEP: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_a && !fire_b && !busy_b |=> !busy_b && !low_driver_out_b)
    else $error("firing a disturbed channel b");
  AST_FIRE_A: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_a && !busy_a && cfg_a_r.count != COUNT_RST |=> low_driver_out_a && busy_a)
    else $error("fire a did not start burst");
  AST_FIRE_B: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_b && !busy_b && cfg_b_r.count != COUNT_RST |=> low_driver_out_b && busy_b)
    else $error("fire b did not start burst");
  AST_COUNT_A: assert property (@(posedge aclk) disable iff (!aresetn)
    done_a |-> pulses[0] == {1'b0, lat_cfg[0].count})
    else $error("wrong pulse count on a");
  AST_ZERO_A: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_a && !busy_a && cfg_a_r.count == COUNT_RST |=> done_a && !busy_a)
    else $error("zero count on a did not finish at once");
  AST_COUNT_B: assert property (@(posedge aclk) disable iff (!aresetn)
    done_b |-> pulses[1] == {1'b0, lat_cfg[1].count})
    else $error("wrong pulse count on b");
  AST_ZERO_B: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_b && !busy_b && cfg_b_r.count == COUNT_RST |=> done_b && !busy_b)
    else $error("zero count on b did not finish at once");
  AST_MODE_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_dual |-> !low_driver_out_a && !low_driver_out_b && !busy_a && !busy_b)
    else $error("outputs active outside dual mode");
  AST_HIGH_A: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(low_driver_out_a) && busy_a |-> hi_run[0] == {1'b0, hi_exp[0]})
    else $error("wrong high time on a");
  AST_LOW_A: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(low_driver_out_a) && lo_run[0] != '0 |-> lo_run[0] == {1'b0, lo_exp[0]})
    else $error("wrong low time on a");
  AST_HIGH_B: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(low_driver_out_b) && busy_b |-> hi_run[1] == {1'b0, hi_exp[1]})
    else $error("wrong high time on b");
  AST_LOW_B: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(low_driver_out_b) && lo_run[1] != '0 |-> lo_run[1] == {1'b0, lo_exp[1]})
    else $error("wrong low time on b");
  AST_STOP_A: assert property (@(posedge aclk) disable iff (!aresetn)
    done_a |-> !busy_a && !low_driver_out_a ##1 !low_driver_out_a)
    else $error("driver a not off after burst");
  AST_IDLE_A: assert property (@(posedge aclk) disable iff (!aresetn)
    !busy_a |-> !low_driver_out_a) else $error("driver a on while idle");
  AST_STOP_B: assert property (@(posedge aclk) disable iff (!aresetn)
    !busy_b |-> !low_driver_out_b) else $error("driver b on while idle");
endmodule

// >>> burst_monitor.sv
// load model of one low-side driver: counts pulses and phase widths
`timescale 1ns/10ps
module burst_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // gate drive seen at the transistor
  input wire logic drive,
  // measurements
  output logic [15:0] pulses,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic prev_r;
  logic [15:0] run_r;
  // a resistive load gives no answer back, so only the gate waveform is recorded
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      run_r <= 16'h0001;
      pulses <= 16'h0000;
      hi_len <= 16'h0000;
      lo_len <= 16'h0000;
    end else begin
      prev_r <= drive;
      if (drive !== prev_r) begin
        run_r <= 16'h0001;
        if (prev_r) begin
          hi_len <= run_r;
        end else begin
          lo_len <= run_r;
        end
        if (drive) begin
          pulses <= pulses + 16'h0001;
        end
      end else begin
        run_r <= run_r + 16'h0001;
      end
    end
  end
endmodule

// >>> test_dual_burst_pulse_generator.sv
// self-checking bench for the dual burst pulse generator
`timescale 1ns/10ps
module test_dual_burst_pulse_generator
  import burst_pkg::*;
;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_v, rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic low_driver_out_a, low_driver_out_b;
  logic [15:0] pulses_a, hi_a, lo_a, pulses_b, hi_b, lo_b;
  int failures, check_count;

  dual_burst_pulse_generator dual_burst_pulse_generator_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .low_driver_out_a, .low_driver_out_b
  );
  burst_monitor mon_a (.aclk(aclk), .aresetn(aresetn), .drive(low_driver_out_a),
    .pulses(pulses_a), .hi_len(hi_a), .lo_len(lo_a));
  burst_monitor mon_b (.aclk(aclk), .aresetn(aresetn), .drive(low_driver_out_b),
    .pulses(pulses_b), .hi_len(hi_b), .lo_len(lo_b));

  task automatic conclude;
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ready lines stay high, so only the valids ever toggle between transfers
  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    bresp_v = s_axi_bresp;
  endtask

  task automatic rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdat = s_axi_rdata;
    rresp = s_axi_rresp;
  endtask

  task automatic t_reset;
    rd(OFF_MODE);
    chk("mode after reset", rdat, 32'h0);
    rd(OFF_COUNT_A);
    chk("count a after reset", rdat, 32'h0);
    rd(OFF_HIGH_B);
    chk("high b after reset", rdat, 32'h0);
    wr(OFF_HIGH_A, 32'h755);
    wr(OFF_HIGH_A, 32'h2aa, 4'h2);
    rd(OFF_HIGH_A);
    chk("high a byte strobe", rdat, 32'h255);
    rd(6'h24);
    chk("unmapped rresp", 32'(rresp), 32'(RESP_SLVERR));
    chk("unmapped rdata", rdat, 32'h0);
    wr(6'h24, 32'hffffffff);
    chk("unmapped bresp", 32'(bresp_v), 32'(RESP_SLVERR));
  endtask

  // every mode but the dual one must ignore both fire bits
  task automatic t_gate;
    int m;
    logic [15:0] pa, pb;
    wr(OFF_COUNT_A, 32'h2);
    wr(OFF_COUNT_B, 32'h2);
    for (m = 0; m < 8; m++) begin
      if (m != 3) begin
        pa = pulses_a;
        pb = pulses_b;
        wr(OFF_MODE, 32'(m));
        rd(OFF_MODE);
        chk("mode readback", rdat, 32'(m));
        wr(OFF_ENABLE, 32'h3);
        repeat (10) @(posedge aclk);
        chk("gated pulses a", 32'(pulses_a - pa), 32'h0);
        chk("gated pulses b", 32'(pulses_b - pb), 32'h0);
      end
    end
  endtask

  // leaving dual mode mid-burst stops the train at once, with no done flag
  task automatic t_abort;
    wr(OFF_MODE, 32'(MODE_DUAL));
    wr(OFF_STATUS, 32'h3);
    wr(OFF_COUNT_A, 32'h3f);
    wr(OFF_HIGH_A, 32'h40);
    wr(OFF_ENABLE, 32'h1);
    chk("abort a started", 32'(low_driver_out_a), 32'h1);
    wr(OFF_MODE, 32'h0);
    chk("abort a off", 32'(low_driver_out_a), 32'h0);
    rd(OFF_ENABLE);
    chk("abort busy", rdat, 32'h0);
    rd(OFF_STATUS);
    chk("abort no done", rdat, 32'h0);
  endtask

  task automatic burst(input int ca, ha, la, cb, hb, lb, input logic [1:0] fire);
    logic [15:0] pa, pb;
    wr(OFF_MODE, 32'(MODE_DUAL));
    wr(OFF_STATUS, 32'h3);
    wr(OFF_COUNT_A, 32'(ca));
    wr(OFF_HIGH_A, 32'(ha));
    wr(OFF_LOW_A, 32'(la));
    wr(OFF_COUNT_B, 32'(cb));
    wr(OFF_HIGH_B, 32'(hb));
    wr(OFF_LOW_B, 32'(lb));
    pa = pulses_a;
    pb = pulses_b;
    wr(OFF_ENABLE, 32'(fire));
    do begin
      rd(OFF_ENABLE);
    end while (rdat[1:0] !== 2'b00);
    chk("pulses a", 32'(pulses_a - pa), fire[0] ? 32'(ca) : 32'h0);
    chk("pulses b", 32'(pulses_b - pb), fire[1] ? 32'(cb) : 32'h0);
    if (fire[0] && ca > 1) begin
      chk("high a", 32'(hi_a), ha > 0 ? 32'(ha) : 32'h1);
      chk("low a", 32'(lo_a), la > 0 ? 32'(la) : 32'h1);
    end
    if (fire[1] && cb > 1) begin
      chk("high b", 32'(hi_b), hb > 0 ? 32'(hb) : 32'h1);
      chk("low b", 32'(lo_b), lb > 0 ? 32'(lb) : 32'h1);
    end
    rd(OFF_STATUS);
    chk("done flags", rdat, 32'(fire));
    repeat (30) @(posedge aclk);
    chk("a held off", 32'(low_driver_out_a), 32'h0);
    chk("b held off", 32'(low_driver_out_b), 32'h0);
    chk("a no extra", 32'(pulses_a - pa), fire[0] ? 32'(ca) : 32'h0);
    chk("b no extra", 32'(pulses_b - pb), fire[1] ? 32'(cb) : 32'h0);
  endtask

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    conclude();
  end

  initial begin
    failures = 0;
    check_count = 0;
    aresetn <= 1'b0;
    s_axi_awaddr <= '0;
    s_axi_awvalid <= 1'b0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'h0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    s_axi_araddr <= '0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_gate();
    // both together with distinct widths, then a alone at the top count
    burst(3, 2, 1, 5, 1, 3, 2'b11);
    burst(63, 0, 0, 4, 2, 2, 2'b01);
    // zero count on a still reports done; widest high time on b
    burst(0, 1, 1, 2, 2047, 3, 2'b11);
    burst(1, 4, 4, 2, 3, 0, 2'b10);
    t_abort();
    conclude();
  end
endmodule
